// ### verilog/tpg_pkg.sv
// Shared constants, types and decode helpers for the CSI-2 test pattern generator
package tpg_pkg;

  // Timing: the clock period and the unit of the programmed line period, both in ns
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINE_UNIT_NS = 10;

  // Stream item layout: {is_hdr, first, last, byte}
  localparam int ITEM_W = 11;
  localparam int HDR_LAST = 2;
  localparam int BLOCK_DEPTH = 16;
  localparam int BUF_DEPTH = 2;

  // Configuration page and packet codes
  localparam logic [7:0] CFG_PAGE = 8'h00;
  localparam logic [5:0] DT_FRAME_START = 6'h00;
  localparam logic [5:0] DT_FRAME_END = 6'h01;
  localparam logic [15:0] SHORT_WC = 16'h0000;
  localparam logic [7:0] INV_MASK = 8'hFF;
  localparam logic [7:0] PAT_RESET = 8'h00;

  typedef enum {ST_IDLE, ST_HDR, ST_PAY} gen_state_t;
  typedef enum {PK_FS, PK_LINE, PK_FE} pkt_kind_t;

  // Reference bar colours in emission order
  function automatic logic [7:0] bar_byte(input logic [2:0] idx);
    case (idx)
      3'h0: bar_byte = 8'hAA;
      3'h1: bar_byte = 8'h33;
      3'h2: bar_byte = 8'hF0;
      3'h3: bar_byte = 8'h7F;
      3'h4: bar_byte = 8'h55;
      3'h5: bar_byte = 8'hCC;
      3'h6: bar_byte = 8'h0F;
      default: bar_byte = 8'h80;
    endcase
  endfunction : bar_byte

  // Bar count select 0..3 means 1, 2, 4 or 8 bars; returns count minus one
  function automatic logic [2:0] bars_m1(input logic [1:0] sel);
    bars_m1 = 3'((4'h1 << sel) - 4'h1);
  endfunction : bars_m1

endpackage : tpg_pkg

// ### verilog/stream_if.sv
// Valid/ready byte-item stream between the generator and its output buffer
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 11);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ### verilog/stream_buf.sv
// Small flip-flop FIFO that keeps items while the transmitter stalls
`timescale 1ns/1ps
module stream_buf #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic resetn,
  stream_if.snk in_s,
  stream_if.src out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic wr_en;
  logic rd_en;

  // Full stalls the generator, so back-pressure reaches the source
  assign in_s.ready = (cnt_ff != FULL_CNT);
  assign out_s.valid = (cnt_ff != '0);
  assign out_s.data = mem_ff[rd_ptr_ff];
  assign wr_en = in_s.valid && in_s.ready;
  assign rd_en = out_s.valid && out_s.ready;

  // Storage, written at the write pointer only
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
    end else if (wr_en) begin
      mem_ff[wr_ptr_ff] <= in_s.data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (wr_en) begin
        wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (rd_en) begin
        rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (wr_en && !rd_en) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (rd_en && !wr_en) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  AST_BUF_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn) // see RQ12
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("stalled item changed or vanished");
  AST_BUF_FULL: assert property (@(posedge sys_clk) disable iff (!resetn) // see RQ12
    (cnt_ff == FULL_CNT) |-> !in_s.ready)
    else $error("buffer accepted while full");

endmodule : stream_buf

// ### verilog/tpg_top.sv
// CSI-2 test pattern generator: frame timing, packet builder and pattern bytes
// Contract
// [RQ1] Two pattern modes, colour bars or fixed colour, chosen by configuration.
// [RQ2] Eight bars emit AA,33,F0,7F,55,CC,0F,80; first seven are bar length.
// [RQ3] Final bar takes all remaining bytes of the line.
// [RQ4] Bars per line selectable as one, two, four or eight.
// [RQ5] Line length and bar length in bytes are separately programmed.
// [RQ6] Packet headers carry programmed datatype and virtual channel.
// [RQ7] Programmed active lines sit inside programmed total lines; rest is blanking.
// [RQ8] Line starts are spaced by the line period in 10 ns units.
// [RQ9] Front porch blank lines follow the last active line before frame end.
// [RQ10] Back porch blank lines follow frame start before the first active line.
// [RQ11] Software keeps bar length a multiple of the datatype block size.
// [RQ12] Runs in the transmit clock domain, hands formatted data directly.
// [RQ13] Fixed-colour mode uses the same frame and line dimensions.
// [RQ14] In fixed-colour mode successive bars alternate data and its complement.
// [RQ15] Fixed-colour block length programmable from one to sixteen bytes.
// [RQ16] Sixteen byte stores hold the value for each block position.
// [RQ17] Configuration is reached only through page zero.
// [RQ18] Software picks a block size holding whole pixels in whole bytes.
// [RQ19] Block index restarts at line start and wraps after the last byte.
// [RQ20] Frames run only while enabled; a cleared enable finishes the frame.
`timescale 1ns/1ps
module tpg_top
  import tpg_pkg::*;
#(
  parameter int LINE_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic mode_fixed,
  input wire logic [1:0] bar_count_sel,
  input wire logic [LINE_W-1:0] line_size,
  input wire logic [LINE_W-1:0] bar_size,
  input wire logic [5:0] data_type,
  input wire logic [1:0] vc_id,
  input wire logic [LINE_W-1:0] act_lines,
  input wire logic [LINE_W-1:0] tot_lines,
  input wire logic [15:0] line_period,
  input wire logic [7:0] vbp_lines,
  input wire logic [7:0] vfp_lines,
  input wire logic [3:0] block_len_m1,
  input wire logic [7:0] cfg_page,
  input wire logic pat_wr,
  input wire logic [3:0] pat_idx,
  input wire logic [7:0] pat_wdata,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_hdr,
  output logic tx_first,
  output logic tx_last,
  output logic frame_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] pat_mem_ff [BLOCK_DEPTH];
  logic busy_ff;
  logic [LINE_W-1:0] ln_ff;
  logic [20:0] ns_ff;
  logic [20:0] slot_cyc_ff;
  logic fs_pend_ff;
  logic line_pend_ff;
  logic fe_pend_ff;
  logic fe_done_ff;
  gen_state_t state_ff;
  pkt_kind_t pkt_ff;
  logic [1:0] hb_ff;
  logic [LINE_W-1:0] pos_ff;
  logic [LINE_W-1:0] bar_pos_ff;
  logic [2:0] bar_idx_ff;
  logic [3:0] blk_ff;
  logic [21:0] nxt_ns;
  logic [21:0] slot_ns;
  logic slot_done;
  logic slot_start;
  logic last_slot;
  logic [LINE_W:0] act_end;
  logic [LINE_W+1:0] fe_line;
  logic in_active;
  logic fs_set;
  logic line_set;
  logic fe_set;
  logic take_fs;
  logic take_line;
  logic take_fe;
  logic push;
  logic hdr_last;
  logic pay_last;
  logic bar_last;
  logic [2:0] colour_idx;
  logic [7:0] hdr_byte;
  logic [7:0] pay_byte;
  logic [15:0] cur_wc;
  logic [5:0] cur_dt;

  stream_if #(.WIDTH(ITEM_W)) gen_s ();
  stream_if #(.WIDTH(ITEM_W)) out_s ();

  ////////////////////////////////////////////////////////////////////////////
  // Fixed-colour byte store, written only when page zero is selected
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < BLOCK_DEPTH; i++) begin
        pat_mem_ff[i] <= PAT_RESET;
      end
    end else if (pat_wr && (cfg_page == CFG_PAGE)) begin // see RQ17
      pat_mem_ff[pat_idx] <= pat_wdata; // see RQ16
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line slot timing; each slot rounds up to whole clocks, so it may run 2 ns long
  assign slot_ns = 22'(line_period) * 22'(LINE_UNIT_NS); // see RQ8
  assign nxt_ns = 22'(ns_ff) + 22'(CLK_PERIOD_NS);
  assign slot_done = busy_ff && (nxt_ns >= slot_ns); // see RQ8
  assign slot_start = busy_ff && (ns_ff == '0);
  assign last_slot = ((LINE_W+1)'(ln_ff) + 1'b1) >= (LINE_W+1)'(tot_lines); // see RQ7

  // Frame sequencing: enable is only looked at between frames
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      ln_ff <= '0;
      ns_ff <= '0;
    end else if (!busy_ff) begin
      if (enable) begin // see RQ20
        busy_ff <= 1'b1;
        ln_ff <= '0;
        ns_ff <= '0;
      end
    end else if (slot_done) begin
      ns_ff <= '0;
      if (last_slot) begin
        busy_ff <= enable; // see RQ20
        ln_ff <= '0;
      end else begin
        ln_ff <= ln_ff + 1'b1;
      end
    end else begin
      ns_ff <= nxt_ns[20:0];
    end
  end

  // Clocks spent in the current slot, counted apart from the ns sum for the period check
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slot_cyc_ff <= '0;
    end else if (!busy_ff || slot_done) begin
      slot_cyc_ff <= '0;
    end else begin
      slot_cyc_ff <= slot_cyc_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line classification: back porch, active lines, front porch, then blanking
  assign act_end = (LINE_W+1)'(vbp_lines) + (LINE_W+1)'(act_lines);
  assign fe_line = (LINE_W+2)'(act_end) + (LINE_W+2)'(vfp_lines); // see RQ9
  assign in_active = ((LINE_W+1)'(ln_ff) >= (LINE_W+1)'(vbp_lines)) // see RQ10
    && ((LINE_W+1)'(ln_ff) < act_end); // see RQ7
  assign fs_set = slot_start && (ln_ff == '0);
  assign line_set = slot_start && in_active;
  // A short total still closes the frame on its last slot
  assign fe_set = slot_start && (((LINE_W+2)'(ln_ff) == fe_line)
    || (last_slot && (!fe_done_ff || (ln_ff == '0))));

  assign take_fs = (state_ff == ST_IDLE) && fs_pend_ff;
  assign take_line = (state_ff == ST_IDLE) && !fs_pend_ff && line_pend_ff;
  assign take_fe = (state_ff == ST_IDLE) && !fs_pend_ff && !line_pend_ff && fe_pend_ff;

  // Pending packet requests; a new request wins over a take in the same cycle
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fs_pend_ff <= 1'b0;
      line_pend_ff <= 1'b0;
      fe_pend_ff <= 1'b0;
      fe_done_ff <= 1'b0;
    end else begin
      fs_pend_ff <= fs_set || (fs_pend_ff && !take_fs);
      line_pend_ff <= line_set || (line_pend_ff && !take_line);
      fe_pend_ff <= fe_set || (fe_pend_ff && !take_fe);
      if (fe_set) begin
        fe_done_ff <= 1'b1;
      end else if (fs_set) begin
        fe_done_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Header fields: short packets carry a zero word count
  assign cur_dt = (pkt_ff == PK_LINE) ? data_type : // see RQ6
    ((pkt_ff == PK_FS) ? DT_FRAME_START : DT_FRAME_END);
  assign cur_wc = (pkt_ff == PK_LINE) ? 16'(line_size) : SHORT_WC; // see RQ5
  always_comb begin
    case (hb_ff)
      2'h0: hdr_byte = {vc_id, cur_dt}; // see RQ6
      2'h1: hdr_byte = cur_wc[7:0];
      default: hdr_byte = cur_wc[15:8];
    endcase
  end

  // Payload byte; both modes share the same line and bar counters
  assign colour_idx = bar_idx_ff << (2'h3 - bar_count_sel); // see RQ4
  always_comb begin
    if (mode_fixed) begin // see RQ1
      pay_byte = pat_mem_ff[blk_ff] ^ (bar_idx_ff[0] ? INV_MASK : 8'h00); // see RQ14
    end else begin
      pay_byte = bar_byte(colour_idx); // see RQ2
    end
  end

  assign hdr_last = (hb_ff == 2'(HDR_LAST))
    && !((pkt_ff == PK_LINE) && (line_size != '0));
  assign pay_last = (pos_ff == line_size - 1'b1);
  assign bar_last = (bar_idx_ff == bars_m1(bar_count_sel));
  assign push = gen_s.valid && gen_s.ready;

  // Generator side of the buffer; the transmitter's stall reaches here
  assign gen_s.valid = (state_ff == ST_HDR) || (state_ff == ST_PAY);
  assign gen_s.data = (state_ff == ST_PAY) ? {1'b0, 1'b0, pay_last, pay_byte}
    : {1'b1, (hb_ff == 2'h0), hdr_last, hdr_byte};

  ////////////////////////////////////////////////////////////////////////////
  // Packet emitter: start of frame first, then line, then end of frame
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      pkt_ff <= PK_FS;
      hb_ff <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          hb_ff <= '0;
          if (take_fs) begin
            pkt_ff <= PK_FS;
            state_ff <= ST_HDR;
          end else if (take_line) begin
            pkt_ff <= PK_LINE;
            state_ff <= ST_HDR;
          end else if (take_fe) begin
            pkt_ff <= PK_FE;
            state_ff <= ST_HDR;
          end
        end
        ST_HDR: begin
          if (push) begin
            hb_ff <= hb_ff + 1'b1;
            if (hb_ff == 2'(HDR_LAST)) begin
              state_ff <= hdr_last ? ST_IDLE : ST_PAY;
            end
          end
        end
        ST_PAY: begin
          if (push && pay_last) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Byte, bar and block counters; all restart before each line payload
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pos_ff <= '0;
      bar_pos_ff <= '0;
      bar_idx_ff <= '0;
      blk_ff <= '0;
    end else if (state_ff != ST_PAY) begin
      pos_ff <= '0;
      bar_pos_ff <= '0;
      bar_idx_ff <= '0;
      blk_ff <= '0; // see RQ19
    end else if (push) begin // see RQ13
      pos_ff <= pos_ff + 1'b1;
      // The last bar never advances, so it soaks up the line remainder
      if ((bar_pos_ff == bar_size - 1'b1) && !bar_last) begin // see RQ3
        bar_idx_ff <= bar_idx_ff + 1'b1;
        bar_pos_ff <= '0;
      end else if (!bar_last) begin
        bar_pos_ff <= bar_pos_ff + 1'b1;
      end
      blk_ff <= (blk_ff == block_len_m1) ? '0 : blk_ff + 1'b1; // see RQ15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output buffer and top-level outputs; stream outputs from buffer flip-flops, frame_busy from busy_ff
  stream_buf #(.WIDTH(ITEM_W), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_s(gen_s.snk),
    .out_s(out_s.src)
  );

  assign out_s.ready = tx_ready; // see RQ12
  assign tx_valid = out_s.valid;
  assign tx_hdr = out_s.data[10];
  assign tx_first = out_s.data[9];
  assign tx_last = out_s.data[8];
  assign tx_data = out_s.data[7:0];
  assign frame_busy = busy_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_BAR_FIRST: assert property ( // see RQ2
    push && (state_ff == ST_PAY) && !mode_fixed && (pos_ff == '0) |-> pay_byte == 8'hAA)
    else $error("first bar byte is not AA");
  AST_BAR_STEP: assert property ( // see RQ4
    push && (state_ff == ST_PAY) && !bar_last && (bar_pos_ff == bar_size - 1'b1) && !pay_last
    |=> bar_idx_ff == $past(bar_idx_ff) + 3'h1)
    else $error("bar did not advance at bar length");
  AST_LAST_BAR: assert property ( // see RQ3
    (state_ff == ST_PAY) && bar_last && push && !pay_last |=> bar_last)
    else $error("final bar was left before line end");
  AST_DI: assert property ( // see RQ6
    push && (state_ff == ST_HDR) && (pkt_ff == PK_LINE) && (hb_ff == 2'h0)
    |-> gen_s.data[7:0] == {vc_id, data_type})
    else $error("line header identifier wrong");
  AST_WC: assert property ( // see RQ5
    push && (state_ff == ST_HDR) && (pkt_ff == PK_LINE) && (hb_ff == 2'h1)
    |-> gen_s.data[7:0] == line_size[7:0])
    else $error("line word count wrong");
  AST_ACTIVE: assert property ( // see RQ7
    line_set |-> ((LINE_W+1)'(ln_ff) >= (LINE_W+1)'(vbp_lines)) && ((LINE_W+1)'(ln_ff) < act_end))
    else $error("active line outside active window");
  AST_VBP: assert property ( // see RQ10
    slot_start && ((LINE_W+1)'(ln_ff) < (LINE_W+1)'(vbp_lines)) |-> !line_set)
    else $error("active line inside back porch");
  AST_PERIOD: assert property ( // see RQ8
    slot_done && (line_period != '0)
    |-> (24'(slot_cyc_ff) * 24'(CLK_PERIOD_NS) < 24'(line_period) * 24'(LINE_UNIT_NS))
    && (24'(slot_cyc_ff + 1'b1) * 24'(CLK_PERIOD_NS) >= 24'(line_period) * 24'(LINE_UNIT_NS)))
    else $error("line slot length wrong");
  AST_VFP: assert property ( // see RQ9
    fe_set && !last_slot |-> (LINE_W+2)'(ln_ff) == fe_line)
    else $error("frame end before front porch done");
  AST_FIXED: assert property ( // see RQ14
    push && (state_ff == ST_PAY) && mode_fixed
    |-> gen_s.data[7:0] == (pat_mem_ff[blk_ff] ^ {8{bar_idx_ff[0]}}))
    else $error("fixed colour byte wrong");
  AST_BLK_WRAP: assert property ( // see RQ19
    push && (state_ff == ST_PAY) && (blk_ff == block_len_m1) && !pay_last |=> blk_ff == 4'h0)
    else $error("block index did not wrap");
  AST_PAGE: assert property ( // see RQ17
    pat_wr && (cfg_page != CFG_PAGE) |=> pat_mem_ff[$past(pat_idx)] == $past(pat_mem_ff[pat_idx]))
    else $error("store written outside page zero");
  AST_ENABLE: assert property ( // see RQ20
    !busy_ff && !enable |=> !busy_ff)
    else $error("frame started while disabled");

endmodule : tpg_top

// ### verification/tx_sink_model.sv
// Transmitter side model: takes stream items, may stall, logs items and packet starts
`timescale 1ns/1ps
module tx_sink_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_hdr,
  input wire logic tx_first,
  input wire logic tx_last,
  output logic tx_ready
);
  logic [10:0] got_q [$];
  int start_q [$];
  // Start values given here so each variable keeps a single writing process
  int cyc = 0;
  logic [31:0] st = 32'h5A17C3E1;

  ////////////////////////////////////////////////////////////////////////////////
  // Ready moves on the falling edge only, so an offer is never cut mid-cycle
  always @(negedge sys_clk) begin
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    tx_ready <= resetn && (!slow || st[0]); // Half the cycles stall when slow
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Item taken on each rising edge where valid and ready agree
  always @(posedge sys_clk) begin
    if (resetn && tx_valid === 1'b1 && tx_ready) begin
      got_q.push_back({tx_hdr, tx_first, tx_last, tx_data});
      if (tx_first === 1'b1) begin
        start_q.push_back(cyc);
      end
    end
    cyc = cyc + 1;
  end

  task clear();
    got_q.delete();
    start_q.delete();
  endtask : clear
endmodule : tx_sink_model

// ### verification/test_csi2_test_pattern_generator.sv
// Self-checking bench for the test pattern generator against a stalling transmitter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); \
  end \
end

module test_csi2_test_pattern_generator
  import tpg_pkg::*;
;
  localparam logic [7:0] COLOURS [8] = '{8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80};
  logic sys_clk, resetn, enable, mode_fixed, pat_wr, slow;
  logic [1:0] bar_count_sel, vc_id;
  logic [15:0] line_size, bar_size, act_lines, tot_lines, line_period;
  logic [5:0] data_type;
  logic [7:0] vbp_lines, vfp_lines, cfg_page, pat_wdata, tx_data;
  logic [3:0] block_len_m1, pat_idx;
  logic tx_valid, tx_ready, tx_hdr, tx_first, tx_last, frame_busy;
  logic [7:0] store_m [16];
  logic [10:0] exp_q [$];
  logic [31:0] rs;
  int fails, samples_checked;

  tpg_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .enable(enable), .mode_fixed(mode_fixed),
    .bar_count_sel(bar_count_sel), .line_size(line_size), .bar_size(bar_size),
    .data_type(data_type), .vc_id(vc_id), .act_lines(act_lines), .tot_lines(tot_lines),
    .line_period(line_period), .vbp_lines(vbp_lines), .vfp_lines(vfp_lines),
    .block_len_m1(block_len_m1), .cfg_page(cfg_page), .pat_wr(pat_wr), .pat_idx(pat_idx),
    .pat_wdata(pat_wdata), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_hdr(tx_hdr), .tx_first(tx_first), .tx_last(tx_last), .frame_busy(frame_busy));

  tx_sink_model sink_u (.sys_clk(sys_clk), .resetn(resetn), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_hdr(tx_hdr), .tx_first(tx_first), .tx_last(tx_last),
    .tx_ready(tx_ready));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  function automatic int rn(input int n);
    return int'(xs() % 32'(n));
  endfunction : rn

  // Payload byte at line position p; the last bar soaks up the remainder
  function automatic logic [7:0] exp_byte(input int p);
    int sel;
    int bi;
    sel = int'(bar_count_sel);
    bi = p / int'(bar_size);
    if (bi > (1 << sel) - 1) bi = (1 << sel) - 1;
    if (mode_fixed) return store_m[p % (int'(block_len_m1) + 1)] ^ ((bi % 2) ? 8'hFF : 8'h00);
    return COLOURS[bi << (3 - sel)];
  endfunction : exp_byte

  task automatic build_exp();
    int ls;
    ls = int'(line_size);
    exp_q.delete();
    exp_q.push_back({3'b110, vc_id, DT_FRAME_START});
    exp_q.push_back({3'b100, 8'h00});
    exp_q.push_back({3'b101, 8'h00});
    for (int l = 0; l < int'(act_lines); l++) begin
      exp_q.push_back({3'b110, vc_id, data_type});
      exp_q.push_back({3'b100, line_size[7:0]});
      exp_q.push_back({2'b10, ls == 0, line_size[15:8]});
      for (int p = 0; p < ls; p++) exp_q.push_back({2'b00, p == ls - 1, exp_byte(p)});
    end
    exp_q.push_back({3'b110, vc_id, DT_FRAME_END});
    exp_q.push_back({3'b100, 8'h00});
    exp_q.push_back({3'b101, 8'h00});
  endtask : build_exp

  // Program geometry and refill the block store, ending with one write on a foreign page
  task automatic cfg(input bit fx, input int sel, ls, bs, act, vbp, vfp, tot, blk);
    @(negedge sys_clk);
    mode_fixed = fx;
    bar_count_sel = 2'(sel);
    line_size = 16'(ls);
    bar_size = 16'(bs);
    act_lines = 16'(act);
    vbp_lines = 8'(vbp);
    vfp_lines = 8'(vfp);
    tot_lines = 16'(tot);
    block_len_m1 = 4'(blk);
    data_type = 6'(xs());
    vc_id = 2'(xs());
    line_period = 16'(2 * (ls + 3) + 10); // Slot long enough for a stalled line
    for (int i = 0; i < 16; i++) begin
      cfg_page = 8'h00;
      pat_wr = 1'b1;
      pat_idx = 4'(i);
      pat_wdata = 8'(xs());
      store_m[i] = pat_wdata;
      @(negedge sys_clk);
    end
    cfg_page = 8'h01;
    pat_idx = 4'(xs());
    pat_wdata = ~store_m[pat_idx];
    @(negedge sys_clk);
    pat_wr = 1'b0;
    cfg_page = 8'h00;
  endtask : cfg

  // One frame: enable until busy, drop it, let the frame and buffer drain, compare
  task automatic run_frame(input string name);
    int n;
    sink_u.clear();
    enable = 1'b1;
    n = 0;
    while (frame_busy !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    enable = 1'b0;
    n = 0;
    while (frame_busy !== 1'b0 && n < 40000) begin
      @(negedge sys_clk);
      n++;
    end
    repeat (40) @(negedge sys_clk);
    `CHK("busy after frame", 1'b0, frame_busy)
    `CHK("valid after frame", 1'b0, tx_valid)
    build_exp();
    `CHK("item count", exp_q.size(), sink_u.got_q.size())
    for (int i = 0; i < exp_q.size() && i < sink_u.got_q.size(); i++) begin
      `CHK("stream item", exp_q[i], sink_u.got_q[i])
    end
    $display("test %s done", name);
  endtask : run_frame

  // Packet starts relative to frame start, in whole line slots
  task automatic check_times(input int act, vbp, vfp);
    int slot;
    int base;
    slot = (int'(line_period) * LINE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    base = (sink_u.start_q.size() > 0) ? sink_u.start_q[0] : 0;
    `CHK("packet starts", act + 2, sink_u.start_q.size())
    if (sink_u.start_q.size() == act + 2) begin
      for (int i = 0; i < act; i++) begin
        `CHK("line start", (vbp + i) * slot, sink_u.start_q[i + 1] - base)
      end
      `CHK("end start", (vbp + act + vfp) * slot, sink_u.start_q[act + 1] - base)
    end
  endtask : check_times

  task wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int v, a, f;
    {sys_clk, resetn, enable, mode_fixed, pat_wr, slow, bar_count_sel, vc_id} = '0;
    {line_size, bar_size, act_lines, tot_lines, line_period, data_type} = '0;
    {vbp_lines, vfp_lines, cfg_page, pat_wdata, block_len_m1, pat_idx} = '0;
    foreach (store_m[i]) store_m[i] = 8'h00;
    fails = 0;
    samples_checked = 0;
    rs = 32'h23E2FB30;
    repeat (20) @(negedge sys_clk);
    `CHK("valid in reset", 1'b0, tx_valid)
    resetn = 1'b1;
    // Eight bars, final bar longer than the rest, no stalls so slot timing is exact
    cfg(0, 3, 26, 3, 2, 1, 1, 6, 0);
    run_frame("bars_timing");
    check_times(2, 1, 1);
    slow = 1'b1;
    for (int s = 0; s < 3; s++) begin
      cfg(0, s, 24 + s * 5, 6, 1, 0, 1, 3, 0);
      run_frame("bar_count");
    end
    // Fixed colour with shortest and longest block, alternating complement per bar
    cfg(1, 2, 20, 3, 2, 1, 0, 4, 0);
    run_frame("fixed_block_one");
    cfg(1, 3, 40, 6, 1, 0, 0, 2, 15);
    run_frame("fixed_block_sixteen");
    // Frame end index past the total count falls on the final slot
    cfg(0, 3, 16, 3, 3, 1, 2, 4, 0);
    run_frame("end_on_last_slot");
    for (int k = 0; k < 6; k++) begin
      v = rn(3);
      a = 1 + rn(3);
      f = rn(3);
      cfg(rn(2), rn(4), rn(48), 3 * (1 + rn(4)), a, v, f, v + a + f + 1, rn(16));
      run_frame("random_frame");
    end
    wrap_up();
  end

  // Watchdog sized well beyond the expected frame traffic
  initial begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end
endmodule : test_csi2_test_pattern_generator
